//--- ss_unit_pkg.sv
// Summary of operation
// - Instructions offered only with feature flag bit 7
// - Disabled stacks fault every op except pointer read
// - Clear busy: validate token, clear busy, privileged
// - Advance pointer by operand count of frames
// - Pointer read copies pointer; disabled means no-op
// - Switch: validate restore token, set busy, move pointer
// - Save previous token onto previous stack
// - Claim: validate level-0 token, set busy, load pointer
// - Guarded store needs flow-control enable, else fault
// - User guarded store accepted only when privileged
//
// Package for the shadow-stack instruction unit: register map, field
// positions, reset values and the shared types. Assumes a 32-bit
// AXI4-Lite register bus with word-aligned offsets.
package ss_unit_pkg;

    // Register byte offsets
    localparam logic [7:0] FEATURE_OFS  = 8'h00;
    localparam logic [7:0] CONTROL_OFS  = 8'h04;
    localparam logic [7:0] USER_CFC_OFS = 8'h08;
    localparam logic [7:0] SUPV_CFC_OFS = 8'h0c;
    localparam logic [7:0] PTR_OFS      = 8'h10;
    localparam logic [7:0] PL0_PTR_OFS  = 8'h14;
    localparam logic [7:0] OPER_A_OFS   = 8'h18;
    localparam logic [7:0] OPER_B_OFS   = 8'h1c;
    localparam logic [7:0] COMMAND_OFS  = 8'h20;
    localparam logic [7:0] RESULT_OFS   = 8'h24;
    localparam logic [7:0] STATUS_OFS   = 8'h28;
    localparam logic [7:0] MASK_OFS     = 8'h2c;
    localparam logic [7:0] MEM_OFS      = 8'h40;
    localparam logic [7:0] MEM_END_OFS  = 8'h7c;

    // Field positions
    localparam int FEATURE_BIT  = 7;
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_PRIV_BIT = 1;
    localparam int CFC_WR_BIT   = 0;
    localparam int TOK_BUSY_BIT = 0;
    localparam int TOK_PREV_BIT = 1;
    localparam int FRAME_SHIFT  = 2;

    // Status / mask bits
    localparam int ST_DONE  = 0;
    localparam int ST_IO    = 1;
    localparam int ST_GP    = 2;
    localparam int ST_TOKEN = 3;

    // Reset values and sizes
    localparam logic [31:0] PTR_RST     = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [3:0]  MASK_RST    = 4'h0;
    localparam int          MEM_DEPTH   = 16;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // Instruction codes written into the command register
    typedef enum logic [3:0] {
        read_pointer_op,
        advance_pointer_op,
        clear_token_busy_op,
        claim_supervisor_token_op,
        switch_stack_restore_op,
        save_previous_token_op,
        guarded_store_op,
        user_guarded_store_op
    } ss_op_e;

    // One issued instruction
    typedef struct packed {
        logic [3:0]  op;
        logic [31:0] oper_a;
        logic [31:0] oper_b;
    } ss_cmd_s;

    // Outcome flags of one instruction
    typedef struct packed {
        logic token;
        logic gp;
        logic io;
        logic done;
    } ss_evt_s;

endpackage

//--- ss_unit.sv
// Shadow-stack instruction unit with AXI4-Lite register access and a
// small flip-flop shadow-stack memory. Assumes a single core clock and
// a master that holds valid and payload until ready.
`timescale 1ns/1ps
module ss_unit
    import ss_unit_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq
);

    parameter logic FEATURE_PRESENT = 1'b1;

    // Applies byte enables to a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Word index of a memory address, used by instructions
    function automatic logic [3:0] widx(input logic [31:0] a);
        return a[5:2];
    endfunction

    logic [31:0] mem_reg [MEM_DEPTH];
    logic [31:0] mem_next [MEM_DEPTH];
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] ucfc_reg, ucfc_next;
    logic [31:0] scfc_reg, scfc_next;
    logic [31:0] ptr_reg, ptr_next;
    logic [31:0] pl0_reg, pl0_next;
    logic [31:0] result_reg, result_next;
    ss_cmd_s     cmd_reg, cmd_next;
    logic        pend_reg, pend_next;
    logic [3:0]  status_reg, status_next;
    logic [3:0]  mask_reg, mask_next;
    logic        irq_reg, irq_next;
    logic        aw_full_reg, aw_full_next;
    logic        w_full_reg, w_full_next;
    logic [7:0]  awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0]  wstrb_reg, wstrb_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic        awready_reg, awready_next;
    logic        wready_reg, wready_next;
    logic        arready_reg, arready_next;

    // Instruction execution, one cycle after the command write
    ss_evt_s     ev;
    logic        ss_en, priv;
    logic [31:0] tok, tok_addr, prev_top;
    always_comb begin
        ss_en    = ctrl_reg[CTRL_EN_BIT];
        priv     = ctrl_reg[CTRL_PRIV_BIT];
        ev       = '0;
        tok      = 32'h0;
        tok_addr = 32'h0;
        prev_top = 32'h0;
        ptr_next = ptr_reg;
        result_next = result_reg;
        for (int i = 0; i < MEM_DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (pend_reg) begin
            ev.done = 1'b1;
            if (!FEATURE_PRESENT) begin
                ev.io = 1'b1;
            end else if (cmd_reg.op == read_pointer_op) begin
                if (ss_en) begin
                    result_next = ptr_reg;
                end
            end else if (!ss_en) begin
                ev.io = 1'b1;
            end else begin
                case (cmd_reg.op)
                    advance_pointer_op: begin
                        ptr_next = ptr_reg + {22'h0,
                            cmd_reg.oper_a[7:0], 2'b00};
                    end
                    clear_token_busy_op: begin
                        tok_addr = cmd_reg.oper_a;
                        tok = mem_reg[widx(tok_addr)];
                        if (!priv) begin
                            ev.gp = 1'b1;
                        end else if (tok[31:3] != tok_addr[31:3]
                                     || !tok[TOK_BUSY_BIT]) begin
                            ev.token = 1'b1;
                        end else begin
                            mem_next[widx(tok_addr)] =
                                {tok[31:1], 1'b0};
                        end
                    end
                    claim_supervisor_token_op: begin
                        tok_addr = pl0_reg;
                        tok = mem_reg[widx(tok_addr)];
                        if (!priv) begin
                            ev.gp = 1'b1;
                        end else if (tok[31:3] != tok_addr[31:3]
                                     || tok[TOK_BUSY_BIT]) begin
                            ev.token = 1'b1;
                        end else begin
                            mem_next[widx(tok_addr)] =
                                {tok[31:1], 1'b1};
                            ptr_next = pl0_reg;
                        end
                    end
                    switch_stack_restore_op: begin
                        // Restore token points one frame above itself
                        tok_addr = cmd_reg.oper_a;
                        tok = mem_reg[widx(tok_addr)];
                        if (tok[31:2] != tok_addr[31:2] + 30'h1
                            || tok[TOK_BUSY_BIT]) begin
                            ev.token = 1'b1;
                        end else begin
                            mem_next[widx(tok_addr)] =
                                {tok[31:1], 1'b1};
                            ptr_next = tok_addr;
                        end
                    end
                    save_previous_token_op: begin
                        // Previous token carries the old stack top
                        tok = mem_reg[widx(ptr_reg)];
                        prev_top = {tok[31:2], 2'b00};
                        if (!tok[TOK_PREV_BIT]) begin
                            ev.token = 1'b1;
                        end else begin
                            mem_next[widx(prev_top - 32'h4)] =
                                prev_top;
                            ptr_next = ptr_reg + 32'h4;
                        end
                    end
                    guarded_store_op: begin
                        if (!(priv ? scfc_reg[CFC_WR_BIT]
                                   : ucfc_reg[CFC_WR_BIT])) begin
                            ev.io = 1'b1;
                        end else begin
                            mem_next[widx(cmd_reg.oper_a)] =
                                cmd_reg.oper_b;
                        end
                    end
                    user_guarded_store_op: begin
                        if (!priv) begin
                            ev.gp = 1'b1;
                        end else begin
                            mem_next[widx(cmd_reg.oper_a)] =
                                cmd_reg.oper_b;
                        end
                    end
                    default: begin
                        ev.io = 1'b1;
                    end
                endcase
            end
        end
        // Bus writes into the memory window never meet an execute cycle
        if (aw_full_reg && w_full_reg && !bvalid_reg
            && awaddr_reg >= MEM_OFS && awaddr_reg <= MEM_END_OFS) begin
            mem_next[awaddr_reg[5:2]] =
                merge(mem_reg[awaddr_reg[5:2]], wdata_reg, wstrb_reg);
        end
    end

    // AXI4-Lite slave: channels captured independently, one write at
    // a time, status read clears but a same-cycle event still sets
    logic wr_go, rd_go, wr_hit;
    logic [3:0] wr_mask;
    always_comb begin
        ctrl_next   = ctrl_reg;
        ucfc_next   = ucfc_reg;
        scfc_next   = scfc_reg;
        pl0_next    = pl0_reg;
        cmd_next    = cmd_reg;
        pend_next   = 1'b0;
        mask_next   = mask_reg;
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        awaddr_next = awaddr_reg;
        wdata_next  = wdata_reg;
        wstrb_next  = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        status_next = status_reg;
        wr_hit      = 1'b1;
        wr_mask     = 4'h0;
        if (s_axi_awvalid && awready_reg) begin
            aw_full_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_full_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end
        wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
        if (wr_go) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            if (awaddr_reg == CONTROL_OFS) begin
                ctrl_next = merge(ctrl_reg, wdata_reg, wstrb_reg);
            end else if (awaddr_reg == USER_CFC_OFS) begin
                ucfc_next = merge(ucfc_reg, wdata_reg, wstrb_reg);
            end else if (awaddr_reg == SUPV_CFC_OFS) begin
                scfc_next = merge(scfc_reg, wdata_reg, wstrb_reg);
            end else if (awaddr_reg == PL0_PTR_OFS) begin
                pl0_next = merge(pl0_reg, wdata_reg, wstrb_reg);
            end else if (awaddr_reg == OPER_A_OFS) begin
                cmd_next.oper_a = merge(cmd_reg.oper_a, wdata_reg,
                                        wstrb_reg);
            end else if (awaddr_reg == OPER_B_OFS) begin
                cmd_next.oper_b = merge(cmd_reg.oper_b, wdata_reg,
                                        wstrb_reg);
            end else if (awaddr_reg == COMMAND_OFS) begin
                cmd_next.op = wdata_reg[3:0];
                pend_next   = 1'b1;
            end else if (awaddr_reg == MASK_OFS) begin
                mask_next = wdata_reg[3:0];
            end else if (awaddr_reg == PTR_OFS
                         || awaddr_reg == FEATURE_OFS
                         || awaddr_reg == RESULT_OFS
                         || awaddr_reg == STATUS_OFS
                         || (awaddr_reg >= MEM_OFS
                             && awaddr_reg <= MEM_END_OFS)) begin
                wr_hit = 1'b1;
            end else begin
                wr_hit = 1'b0;
            end
            bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        rd_go = s_axi_arvalid && arready_reg;
        if (rd_go) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0;
            if (s_axi_araddr == FEATURE_OFS) begin
                rdata_next[FEATURE_BIT] = FEATURE_PRESENT;
            end else if (s_axi_araddr == CONTROL_OFS) begin
                rdata_next = ctrl_reg;
            end else if (s_axi_araddr == USER_CFC_OFS) begin
                rdata_next = ucfc_reg;
            end else if (s_axi_araddr == SUPV_CFC_OFS) begin
                rdata_next = scfc_reg;
            end else if (s_axi_araddr == PTR_OFS) begin
                rdata_next = ptr_reg;
            end else if (s_axi_araddr == PL0_PTR_OFS) begin
                rdata_next = pl0_reg;
            end else if (s_axi_araddr == OPER_A_OFS) begin
                rdata_next = cmd_reg.oper_a;
            end else if (s_axi_araddr == OPER_B_OFS) begin
                rdata_next = cmd_reg.oper_b;
            end else if (s_axi_araddr == COMMAND_OFS) begin
                rdata_next = {27'h0, pend_reg, cmd_reg.op};
            end else if (s_axi_araddr == RESULT_OFS) begin
                rdata_next = result_reg;
            end else if (s_axi_araddr == STATUS_OFS) begin
                rdata_next  = {28'h0, status_reg};
                wr_mask     = status_reg;
            end else if (s_axi_araddr == MASK_OFS) begin
                rdata_next = {28'h0, mask_reg};
            end else if (s_axi_araddr >= MEM_OFS
                         && s_axi_araddr <= MEM_END_OFS) begin
                rdata_next = mem_reg[s_axi_araddr[5:2]];
            end else begin
                rresp_next = RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        // Clear what was read, then let new events set again
        status_next  = (status_reg & ~wr_mask) | ev;
        irq_next     = |(status_next & mask_next);
        awready_next = !aw_full_next;
        wready_next  = !w_full_next;
        arready_next = !rvalid_next;
    end

    // Register stage for all state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_reg[i] <= 32'h0;
            end
            ctrl_reg    <= CTRL_RST;
            ucfc_reg    <= 32'h0;
            scfc_reg    <= 32'h0;
            ptr_reg     <= PTR_RST;
            pl0_reg     <= 32'h0;
            result_reg  <= 32'h0;
            cmd_reg     <= '0;
            pend_reg    <= 1'b0;
            status_reg  <= 4'h0;
            mask_reg    <= MASK_RST;
            irq_reg     <= 1'b0;
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= RESP_OKAY;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            arready_reg <= 1'b0;
        end else begin
            mem_reg     <= mem_next;
            ctrl_reg    <= ctrl_next;
            ucfc_reg    <= ucfc_next;
            scfc_reg    <= scfc_next;
            ptr_reg     <= ptr_next;
            pl0_reg     <= pl0_next;
            result_reg  <= result_next;
            cmd_reg     <= cmd_next;
            pend_reg    <= pend_next;
            status_reg  <= status_next;
            mask_reg    <= mask_next;
            irq_reg     <= irq_next;
            aw_full_reg <= aw_full_next;
            w_full_reg  <= w_full_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            arready_reg <= arready_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign irq           = irq_reg;

endmodule

//--- ss_unit_properties.sv
// Bus-level checker for the shadow-stack instruction unit.
// Sees only the top-level ports; attached to every ss_unit by bind.
`timescale 1ns/1ps
module ss_unit_properties
    import ss_unit_pkg::*;
#(
    parameter logic FEATURE_PRESENT = 1'b1
)(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Holes in the map; misaligned offsets are left out on purpose
    wire logic ar_bad = (s_axi_araddr inside {[8'h30:8'h3c]}) ||
                        s_axi_araddr > 8'h7c;
    wire logic aw_bad = (s_axi_awaddr inside {[8'h30:8'h3c]}) ||
                        s_axi_awaddr > 8'h7c;
    // A queued write may delay the next answer, so only a fresh pair counts
    wire logic wr_pair = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                         s_axi_wready && !s_axi_bvalid;
    wire logic rd_take = s_axi_arvalid && s_axi_arready;

    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before rready");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    read_lat_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read answer late");
    write_lat_a: assert property (wr_pair |-> ##2 s_axi_bvalid)
        else $error("write response late");
    rd_err_a: assert property (rd_take && ar_bad |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    wr_err_a: assert property (wr_pair && aw_bad |->
        ##2 s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    feature_bit_a: assert property (
        rd_take && s_axi_araddr == FEATURE_OFS |=>
        s_axi_rdata[FEATURE_BIT] == FEATURE_PRESENT)
        else $error("feature flag wrong");
endmodule

bind ss_unit ss_unit_properties #(.FEATURE_PRESENT(FEATURE_PRESENT)) u_props (
    .mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

//--- ss_unit_tb.sv
// Self-checking bench for the shadow-stack instruction unit.
// Acts as the AXI4-Lite master itself; one 100 MHz clock.
`timescale 1ns/1ps
module ss_unit_tb
    import ss_unit_pkg::*;
();
    localparam logic [31:0] DN = 32'h1;
    localparam logic [31:0] IO = DN | (32'h1 << ST_IO);
    localparam logic [31:0] GP = DN | (32'h1 << ST_GP);
    localparam logic [31:0] TK = DN | (32'h1 << ST_TOKEN);
    logic        mclk, rst_n, irq, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          fails = 0;
    int          compares = 0;

    ss_unit u_dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

    always #5 mclk = ~mclk;

    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    // Address and data go out together; each drops once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        check($sformatf("reg %h", a), rdat, e);
    endtask

    // The command executes on the edge after the one that raises its write answer
    task op(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b);
        wr(OPER_A_OFS, a);
        wr(OPER_B_OFS, b);
        wr(COMMAND_OFS, {28'h0, c});
    endtask

    task t_reset;
        rd(FEATURE_OFS);
        check("feature", rdat & 32'h80, 32'h80);
        rdchk(PTR_OFS, PTR_RST);
        rdchk(CONTROL_OFS, CTRL_RST);
        rdchk(MASK_OFS, {28'h0, MASK_RST});
    endtask

    // Every code but pointer read faults, including an unknown one
    task t_disabled;
        logic [3:0] c;
        wr(MASK_OFS, 32'h2);
        for (c = 4'h1; c != 4'h9; c++) begin
            op(c, 32'h4, 32'h0);
            repeat (2) @(posedge mclk);
            check("irq set", {31'h0, irq}, 32'h1);
            rdchk(STATUS_OFS, IO);
            repeat (2) @(posedge mclk);
            check("irq clear", {31'h0, irq}, 32'h0);
        end
        op(read_pointer_op, 32'h0, 32'h0);
        rdchk(STATUS_OFS, DN);
        rdchk(PTR_OFS, PTR_RST);
    endtask

    task t_claim;
        wr(CONTROL_OFS, 32'h3);
        wr(PL0_PTR_OFS, 32'h44);
        wr(8'h44, 32'h44);
        op(claim_supervisor_token_op, 32'h0, 32'h0);
        rdchk(PTR_OFS, 32'h44);
        rdchk(8'h44, 32'h45);
        op(read_pointer_op, 32'h0, 32'h0);
        rdchk(RESULT_OFS, 32'h44);
        op(advance_pointer_op, 32'h2, 32'h0);
        rdchk(PTR_OFS, 32'h4c);
        rdchk(STATUS_OFS, DN);
    endtask

    task t_tokens;
        op(clear_token_busy_op, 32'h44, 32'h0);
        rdchk(8'h44, 32'h44);
        op(clear_token_busy_op, 32'h44, 32'h0);
        rdchk(STATUS_OFS, TK);
        rdchk(8'h44, 32'h44);
        wr(8'h44, 32'h50);
        op(claim_supervisor_token_op, 32'h0, 32'h0);
        rdchk(STATUS_OFS, TK);
        rdchk(PTR_OFS, 32'h4c);
        rdchk(8'h44, 32'h50);
    endtask

    // Privileged ops from user level; protection events are masked
    task t_unpriv;
        wr(CONTROL_OFS, 32'h1);
        wr(8'h44, 32'h45);
        wr(8'h78, 32'h0);
        op(clear_token_busy_op, 32'h44, 32'h0);
        repeat (2) @(posedge mclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        rdchk(STATUS_OFS, GP);
        rdchk(8'h44, 32'h45);
        op(claim_supervisor_token_op, 32'h0, 32'h0);
        rdchk(STATUS_OFS, GP);
        rdchk(PTR_OFS, 32'h4c);
        op(user_guarded_store_op, 32'h78, 32'h33);
        rdchk(STATUS_OFS, GP);
        rdchk(8'h78, 32'h0);
    endtask

    task t_store;
        op(guarded_store_op, 32'h70, 32'h11);
        rdchk(STATUS_OFS, IO);
        wr(USER_CFC_OFS, 32'h1);
        op(guarded_store_op, 32'h70, 32'h11);
        rdchk(8'h70, 32'h11);
        wr(CONTROL_OFS, 32'h3);
        op(guarded_store_op, 32'h74, 32'h22);
        rdchk(STATUS_OFS, IO);
        wr(SUPV_CFC_OFS, 32'h1);
        op(guarded_store_op, 32'h74, 32'h22);
        rdchk(8'h74, 32'h22);
        op(user_guarded_store_op, 32'h78, 32'h33);
        rdchk(8'h78, 32'h33);
        rdchk(STATUS_OFS, DN);
    endtask

    task t_switch;
        wr(8'h58, 32'h5c);
        op(switch_stack_restore_op, 32'h58, 32'h0);
        rdchk(8'h58, 32'h5d);
        rdchk(PTR_OFS, 32'h58);
        wr(8'h58, 32'h62);
        op(save_previous_token_op, 32'h0, 32'h0);
        rdchk(8'h5c, 32'h60);
        rdchk(PTR_OFS, 32'h5c);
        op(switch_stack_restore_op, 32'h58, 32'h0);
        rdchk(STATUS_OFS, TK);
        rdchk(PTR_OFS, 32'h5c);
    endtask

    task t_bus;
        rd(8'h30);
        check("rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        check("rdata", rdat, 32'h0);
        wr(8'h84, 32'h1);
        check("bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(PTR_OFS, 32'h123);
        check("bresp ro", {30'h0, resp}, {30'h0, RESP_OKAY});
        rdchk(PTR_OFS, 32'h5c);
    endtask

    task stop_test;
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog: the whole run needs only a few hundred cycles
    initial begin
        #100us;
        fails++;
        stop_test;
    end

    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_disabled;
        t_claim;
        t_tokens;
        t_unpriv;
        t_store;
        t_switch;
        t_bus;
        stop_test;
    end
endmodule
